// ==== inc/ddr_link_pkg.sv ====
// Purpose: Shared commands, mode register layout and timing constants.
// Assumes: Link clock is built by the controller from clk_sys.
// Notes:   Counts in nck are link clock rising edges.
package ddr_link_pkg;

    // Link command codes
    typedef enum logic [3:0] {
        CMD_NOP  = 4'h0,
        CMD_MRS  = 4'h1,
        CMD_ACT  = 4'h2,
        CMD_PRE  = 4'h3,
        CMD_WR   = 4'h4,
        CMD_RD   = 4'h5,
        CMD_RDA  = 4'h6,
        CMD_REF  = 4'h7,
        CMD_SHORT_CALIBRATION_CMD = 4'h8
    } cmd_t;

    // Clocking
    localparam int SYS_PERIOD_NS = 25;
    localparam int CK_DIV        = 4;      // clk_sys cycles per link clock half period

    // Mode register layout
    localparam int         MR_SEL_LSB   = 14;
    localparam int         MR0_BL_LSB   = 0;
    localparam int         MR0_WR_LSB   = 9;
    localparam int         MR1_LEV_BIT  = 7;
    localparam int         MR2_CWL_LSB  = 3;
    localparam int         MR3_MPR_BIT  = 2;
    localparam logic [1:0] BL_BC4_FIXED = 2'h2;
    localparam logic [3:0] CWL_BASE     = 4'h5;
    localparam logic [4:0] WR_CODE0_CYC = 5'h10;
    localparam logic [4:0] WR_CODE_BASE = 5'h04;
    localparam logic [15:0] MR0_RST     = 16'h0000;

    // Timing in nck unless named _NS
    localparam logic [7:0] LEV_FIRST_NCK  = 8'h28;  // 40
    localparam logic [7:0] LEV_DQSEN_NCK  = 8'h19;  // 25
    localparam logic [7:0] MRS_GAP_NCK    = 8'h04;
    localparam logic [7:0] CMD_GAP_NCK    = 8'h01;
    localparam logic [4:0] WR_OFS_BL8     = 5'h04;
    localparam logic [4:0] WR_OFS_BC4     = 5'h02;
    localparam int         WR_NS          = 15;
    localparam logic [7:0] REFPDEN_NCK    = 8'h01;
    localparam int         XPDLL_NS       = 24;
    localparam logic [7:0] XPDLL_MIN_NCK  = 8'h0a;
    localparam logic [7:0] BURST_NCK      = 8'h04;
    localparam logic [7:0] MPR_GAP_NCK    = 8'h01;
    localparam logic [6:0] SHORT_CALIBRATION_CMD_NCK       = 7'h40;  // 64
    localparam logic [7:0] ROW_OP_NCK     = 8'h04;
    localparam logic [7:0] REF_OP_NCK     = 8'h14;
    localparam int         REFI_NS        = 7800;

    // Nanoseconds to whole link clocks, rounded up
    function automatic int ns_to_nck(input int t_ns, input int tck_ns);
        return (t_ns + tck_ns - 1) / tck_ns;
    endfunction

endpackage

// ==== inc/ddr_link_if.sv ====
`timescale 1ns/1ps
// Purpose: Link between controller end and memory end.
// Assumes: Both ends run on their own clk_sys.
// Notes:   dqs_oe_n low while the controller drives the strobe.
interface ddr_link_if;
    logic        ck;
    logic        cke;
    logic [3:0]  cmd;
    logic [15:0] addr;
    logic        dqs;
    logic        dqs_oe_n;
    logic        lev_fb;

    modport ctrl (output ck, output cke, output cmd, output addr, output dqs, output dqs_oe_n, input lev_fb);
    modport dram (input ck, input cke, input cmd, input addr, input dqs, input dqs_oe_n, output lev_fb);
endinterface

// ==== design/ddr_dram_end.sv ====
`timescale 1ns/1ps
// Purpose: Memory end: mode registers, write start, calibration, power state.
// Assumes: Every link pin is synchronised to clk_sys before use.
// Notes:   Link clock edges are found from the synchronised clock.
module ddr_dram_end
    import ddr_link_pkg::*;
(
    ddr_link_if.dram    link,
    input  wire logic   clk_sys,
    input  wire logic   rstn,
    output logic        int_write_start,
    output logic [4:0]  write_recovery,
    output logic        power_down,
    output logic        calibrating,
    output logic        cal_step,
    output logic        leveling
);
    import ddr_link_pkg::*;

    typedef struct packed {
        logic [2:0]  ck_p;        // s1, s2, delayed
        logic [1:0]  cke_p;
        logic [7:0]  cmd_p;
        logic [31:0] addr_p;
        logic [2:0]  dqs_p;
        logic [1:0]  oe_p;
        logic [1:0]  burst;
        logic [4:0]  wr_cyc;
        logic [3:0]  wl;
        logic        lev_on;
        logic [4:0]  wcnt;
        logic [7:0]  busy;
        logic [6:0]  zq;
        logic        fb;
        logic        wstart;
        logic        pd;
        logic        step;
    } dram_state_t;

    localparam dram_state_t S_RST = '{wr_cyc: WR_CODE0_CYC, wl: CWL_BASE, default: '0};

    dram_state_t s_r;
    dram_state_t s_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic       rise;
        logic [3:0] cmd;
        logic [15:0] adr;
        logic [2:0]  wcode;
        s_nxt = s_r;
        // Two-stage synchronisers; stage two is read, plus the delayed copy for ck and dqs
        s_nxt.ck_p   = {s_r.ck_p[1:0], link.ck};
        s_nxt.cke_p  = {s_r.cke_p[0], link.cke};
        s_nxt.cmd_p  = {s_r.cmd_p[3:0], link.cmd};
        s_nxt.addr_p = {s_r.addr_p[15:0], link.addr};
        s_nxt.dqs_p  = {s_r.dqs_p[1:0], link.dqs};
        s_nxt.oe_p   = {s_r.oe_p[0], link.dqs_oe_n};
        rise  = s_r.ck_p[1] & ~s_r.ck_p[2];
        cmd   = s_r.cmd_p[7:4];
        adr   = s_r.addr_p[31:16];
        wcode = adr[MR0_WR_LSB +: 3];
        s_nxt.wstart = 1'b0;
        s_nxt.step   = 1'b0;
        // Every timer steps on a real link clock edge
        if (rise) begin
            if (s_r.wcnt != 5'h00) begin
                s_nxt.wcnt   = s_r.wcnt - 5'h01;
                s_nxt.wstart = (s_r.wcnt == 5'h01);
            end
            if (s_r.busy != 8'h00) begin
                s_nxt.busy = s_r.busy - 8'h01;
            end
            if (s_r.zq != 7'h00) begin
                s_nxt.zq   = s_r.zq - 7'h01;
                s_nxt.step = (s_r.zq == 7'h01);
            end
            if (s_r.cke_p[1]) begin
                unique case (cmd)
                    CMD_MRS: begin
                        unique case (adr[MR_SEL_LSB +: 2])
                            2'h0: begin
                                s_nxt.burst  = adr[MR0_BL_LSB +: 2];
                                s_nxt.wr_cyc = (wcode == 3'h0) ? WR_CODE0_CYC : WR_CODE_BASE + {2'h0, wcode};
                            end
                            2'h1: s_nxt.lev_on = adr[MR1_LEV_BIT];
                            2'h2: s_nxt.wl = CWL_BASE + {1'b0, adr[MR2_CWL_LSB +: 3]};
                            2'h3: ;
                        endcase
                    end
                    CMD_WR: begin
                        // Chop fixed by mode register starts 2 early
                        s_nxt.wcnt = {1'b0, s_r.wl} + ((s_r.burst == BL_BC4_FIXED) ? WR_OFS_BC4 : WR_OFS_BL8);
                    end
                    CMD_ACT, CMD_PRE, CMD_RDA: s_nxt.busy = ROW_OP_NCK;
                    CMD_REF:  s_nxt.busy = REF_OP_NCK;
                    CMD_SHORT_CALIBRATION_CMD: s_nxt.zq = SHORT_CALIBRATION_CMD_NCK;
                    default: ;
                endcase
            end
        end
        // Leveling: report clock level seen at each strobe rise
        if (s_r.lev_on && !s_r.oe_p[1] && s_r.dqs_p[1] && !s_r.dqs_p[2]) begin
            s_nxt.fb = s_r.ck_p[1];
        end
        // Power-down level only once row work and calibration are done
        s_nxt.pd = ~s_r.cke_p[1] & (s_r.busy == 8'h00) & (s_r.zq == 7'h00);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_r <= S_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign link.lev_fb     = s_r.fb;
    assign int_write_start = s_r.wstart;
    assign write_recovery  = s_r.wr_cyc;
    assign power_down      = s_r.pd;
    assign calibrating     = (s_r.zq != 7'h00);
    assign cal_step        = s_r.step;
    assign leveling        = s_r.lev_on;
endmodule

// ==== design/ddr_ctrl_end.sv ====
`timescale 1ns/1ps
// Purpose: Controller end: makes link clock, issues commands, keeps gaps.
// Assumes: One user request at a time; pd_req is a level.
// Notes:   Commands change on link clock fall and hold one period.
module ddr_ctrl_end
    import ddr_link_pkg::*;
#(
    parameter int DIV = ddr_link_pkg::CK_DIV
)
(
    ddr_link_if.ctrl    link,
    input  wire logic   clk_sys,
    input  wire logic   rstn,
    input  wire logic   req_valid,
    input  wire ddr_link_pkg::cmd_t req_cmd,
    input  wire logic [15:0] req_addr,
    output logic        req_ready,
    input  wire logic   pd_req,
    output logic        pd_active,
    output logic        ref_due,
    output logic        lev_done,
    output logic        lev_result
);
    import ddr_link_pkg::*;

    localparam int TCK_NS = 2 * DIV * SYS_PERIOD_NS;
    // Rounded-up conversions
    localparam logic [4:0] WR_NCK    = 5'(ns_to_nck(WR_NS, TCK_NS));
    localparam int         XPDLL_C   = ns_to_nck(XPDLL_NS, TCK_NS);
    localparam logic [7:0] XPDLL_NCK = (XPDLL_C > int'(XPDLL_MIN_NCK)) ? 8'(XPDLL_C) : XPDLL_MIN_NCK;
    // Refresh timer runs on clk_sys, so a slow link clock cannot stretch it
    localparam logic [15:0] REFI_SYS = 16'(REFI_NS / SYS_PERIOD_NS);

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ARM  = 5'b00010,
        ST_HOLD = 5'b00100,
        ST_LEV  = 5'b01000,
        ST_PD   = 5'b10000
    } ctrl_st_t;

    typedef struct packed {
        ctrl_st_t    st;
        logic [7:0]  div;
        logic        ck;
        logic        cke;
        cmd_t        cmd;
        logic [15:0] addr;
        logic        dqs;
        logic        dqs_oe_n;
        logic [1:0]  fb_p;
        cmd_t        pend_cmd;
        logic [15:0] pend_addr;
        logic        lev_next;
        logic [7:0]  gap;
        logic [7:0]  lev;
        logic [7:0]  pd_gap;
        logic [7:0]  dll;
        logic [7:0]  mpr_gap;
        logic [3:0]  wl;
        logic        bc4f;
        logic        mpr_on;
        logic [15:0] refi;
        logic        due;
        logic        ready;
        logic        done;
        logic        result;
    } ctrl_state_t;

    localparam ctrl_state_t S_RST = '{st: ST_IDLE, cke: 1'b1, dqs_oe_n: 1'b1, cmd: CMD_NOP,
                                      pend_cmd: CMD_NOP, wl: CWL_BASE, refi: REFI_SYS, default: '0};

    ctrl_state_t s_r;
    ctrl_state_t s_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic rise;
        logic fall;
        logic legal;
        logic [15:0] a;
        s_nxt = s_r;
        rise  = 1'b0;
        fall  = 1'b0;
        a     = s_r.pend_addr;
        s_nxt.done = 1'b0;
        s_nxt.fb_p = {s_r.fb_p[0], link.lev_fb};
        // Link clock divider; clock leaves on a flip-flop
        if (s_r.div == 8'(DIV - 1)) begin
            s_nxt.div = 8'h00;
            s_nxt.ck  = ~s_r.ck;
            rise      = ~s_r.ck;
            fall      = s_r.ck;
        end else begin
            s_nxt.div = s_r.div + 8'h01;
        end
        // Gap timers count link clock edges, not time
        if (rise) begin
            if (s_r.gap != 8'h00)     s_nxt.gap = s_r.gap - 8'h01;
            if (s_r.lev != 8'h00)     s_nxt.lev = s_r.lev - 8'h01;
            if (s_r.pd_gap != 8'h00)  s_nxt.pd_gap = s_r.pd_gap - 8'h01;
            if (s_r.dll != 8'h00)     s_nxt.dll = s_r.dll - 8'h01;
            if (s_r.mpr_gap != 8'h00) s_nxt.mpr_gap = s_r.mpr_gap - 8'h01;
        end
        // Pending command may go only when its own gaps are met
        legal = (s_r.gap == 8'h00);
        if (s_r.pend_cmd == CMD_RD || s_r.pend_cmd == CMD_RDA) begin
            legal = legal & (s_r.dll == 8'h00);
        end
        if (s_r.pend_cmd == CMD_MRS) begin
            legal = legal & (s_r.mpr_gap == 8'h00);
        end
        // Issuing a refresh clears the flag first so a new expiry still sets it
        if (s_r.st == ST_ARM && fall && legal && s_r.pend_cmd == CMD_REF) begin
            s_nxt.due = 1'b0;
        end
        if (s_r.refi == 16'h0000) begin
            s_nxt.refi = REFI_SYS;
            s_nxt.due  = 1'b1;
        end else begin
            s_nxt.refi = s_r.refi - 16'h0001;
        end
        unique case (s_r.st)
            ST_IDLE: begin
                if (s_r.due) begin
                    s_nxt.pend_cmd = CMD_REF;
                    s_nxt.st       = ST_ARM;
                end else if (req_valid && s_r.ready) begin
                    s_nxt.pend_cmd  = req_cmd;
                    s_nxt.pend_addr = req_addr;
                    s_nxt.st        = ST_ARM;
                end else if (pd_req && fall && s_r.pd_gap == 8'h00) begin
                    // Row work may still be running here
                    s_nxt.cke = 1'b0;
                    s_nxt.st  = ST_PD;
                end
            end
            ST_ARM: begin
                if (fall && legal) begin
                    s_nxt.cmd      = s_r.pend_cmd;
                    s_nxt.addr     = a;
                    s_nxt.gap      = CMD_GAP_NCK;
                    s_nxt.lev_next = 1'b0;
                    s_nxt.st       = ST_HOLD;
                    unique case (s_r.pend_cmd)
                        CMD_MRS: begin
                            s_nxt.gap = MRS_GAP_NCK;
                            unique case (a[MR_SEL_LSB +: 2])
                                2'h0: s_nxt.bc4f = (a[MR0_BL_LSB +: 2] == BL_BC4_FIXED);
                                2'h1: begin
                                    s_nxt.lev_next = a[MR1_LEV_BIT];
                                    s_nxt.lev      = LEV_FIRST_NCK;
                                end
                                2'h2: s_nxt.wl = CWL_BASE + {1'b0, a[MR2_CWL_LSB +: 3]};
                                2'h3: s_nxt.mpr_on = a[MR3_MPR_BIT];
                            endcase
                        end
                        CMD_WR: begin
                            // Write to powerdown: latency, burst, rounded recovery
                            s_nxt.pd_gap = 8'({1'b0, s_r.wl} + (s_r.bc4f ? WR_OFS_BC4 : WR_OFS_BL8) + WR_NCK);
                        end
                        CMD_REF: begin
                            s_nxt.pd_gap = REFPDEN_NCK + XPDLL_NCK;
                        end
                        CMD_RD, CMD_RDA: begin
                            if (s_r.mpr_on) begin
                                s_nxt.mpr_gap = BURST_NCK + MPR_GAP_NCK;
                            end
                        end
                        CMD_SHORT_CALIBRATION_CMD: s_nxt.gap = {1'b0, SHORT_CALIBRATION_CMD_NCK};
                        default: ;
                    endcase
                end
            end
            ST_HOLD: begin
                if (fall) begin
                    s_nxt.cmd = CMD_NOP;
                    s_nxt.st  = s_r.lev_next ? ST_LEV : ST_IDLE;
                end
            end
            ST_LEV: begin
                // Strobe driven only after the enable delay
                if (s_r.lev <= LEV_FIRST_NCK - LEV_DQSEN_NCK) begin
                    s_nxt.dqs_oe_n = 1'b0;
                end
                if (fall && s_r.dqs) begin
                    s_nxt.dqs      = 1'b0;
                    s_nxt.dqs_oe_n = 1'b1;
                    s_nxt.done     = 1'b1;
                    s_nxt.result   = s_r.fb_p[1];
                    s_nxt.st       = ST_IDLE;
                end else if (fall && s_r.lev == 8'h00 && !s_r.dqs_oe_n) begin
                    s_nxt.dqs = 1'b1;
                end
            end
            ST_PD: begin
                if (!pd_req && fall) begin
                    s_nxt.cke = 1'b1;
                    s_nxt.dll = XPDLL_NCK;
                    s_nxt.st  = ST_IDLE;
                end
            end
        endcase
        s_nxt.ready = (s_nxt.st == ST_IDLE) & ~s_nxt.due & ~(req_valid & s_r.ready);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_r <= S_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign link.ck       = s_r.ck;
    assign link.cke      = s_r.cke;
    assign link.cmd      = s_r.cmd;
    assign link.addr     = s_r.addr;
    assign link.dqs      = s_r.dqs;
    assign link.dqs_oe_n = s_r.dqs_oe_n;
    assign req_ready     = s_r.ready;
    assign pd_active     = (s_r.st == ST_PD);
    assign ref_due       = s_r.due;
    assign lev_done      = s_r.done;
    assign lev_result    = s_r.result;
endmodule

// ==== verification/ddr_link_monitor.sv ====
// Purpose: Timing checks on the link between the two ends.
// Assumes: DIV of 4, so one link clock period is 8 clk_sys cycles.
// Notes:   Counts are link clock rises seen on clk_sys, saturating.
`timescale 1ns/1ps
module ddr_link_monitor
    import ddr_link_pkg::*;
(
    input logic        clk_sys,
    input logic        rstn,
    input logic        ck,
    input logic        cke,
    input logic [3:0]  cmd,
    input logic [15:0] addr,
    input logic        dqs,
    input logic        dqs_oe_n,
    input logic        lev_fb
);
    logic       ck_q_r;
    logic       cke_q_r;
    logic       lev_on_r;
    logic [3:0] last_r;
    logic [7:0] since_r;
    logic [7:0] lev_r;
    logic [7:0] ref_r;
    logic [7:0] exit_r;
    logic       rise;
    logic       issue;
    logic [7:0] lev_now;

    // Commands are taken as issued on a link clock fall
    assign rise    = ck & ~ck_q_r;
    assign issue   = ck_q_r & ~ck & (cmd != CMD_NOP);
    assign lev_now = lev_r + {7'h00, rise};

    function automatic logic [7:0] bump(input logic [7:0] v, input logic en);
        return (en && v != 8'hff) ? v + 8'h01 : v;
    endfunction

    // Rises since last command, leveling set, refresh and wake-up
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ck_q_r   <= 1'b0;
            cke_q_r  <= 1'b1;
            lev_on_r <= 1'b0;
            last_r   <= CMD_NOP;
            since_r  <= 8'hff;
            lev_r    <= 8'h00;
            ref_r    <= 8'hff;
            exit_r   <= 8'hff;
        end else begin
            ck_q_r  <= ck;
            cke_q_r <= cke;
            since_r <= issue ? 8'h00 : bump(since_r, rise);
            last_r  <= issue ? cmd : last_r;
            if (issue && cmd == CMD_MRS && addr[15:14] == 2'h1) begin
                lev_r    <= 8'h00;
                lev_on_r <= addr[MR1_LEV_BIT];
            end else begin
                lev_r <= bump(lev_r, rise);
            end
            ref_r  <= (issue && cmd == CMD_REF) ? 8'h00 : bump(ref_r, rise);
            exit_r <= (cke && !cke_q_r) ? 8'h00 : bump(exit_r, rise);
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // Strobe stands one link period, then is released
    sequence s_strobe_high;
        dqs [*8];
    endsequence
    sequence s_strobe_free;
        !dqs ##[0:2] dqs_oe_n;
    endsequence

    a_mrs_gap_four: assert property (issue && last_r == CMD_MRS |-> since_r >= MRS_GAP_NCK)
        else $error("mode set followed too soon");
    a_cmd_gap_one: assert property (issue |-> since_r >= CMD_GAP_NCK)
        else $error("commands closer than one link clock");
    a_zq_gap_full: assert property (issue && last_r == CMD_SHORT_CALIBRATION_CMD |-> since_r >= {1'b0, SHORT_CALIBRATION_CMD_NCK})
        else $error("command during calibration");
    a_lev_first_rise: assert property ($rose(dqs) |-> lev_on_r && lev_now >= LEV_FIRST_NCK)
        else $error("leveling strobe rose early");
    a_lev_oe_delay: assert property ($fell(dqs_oe_n) |-> lev_on_r && lev_now >= LEV_DQSEN_NCK)
        else $error("strobe driven early");
    a_strobe_owned: assert property (dqs |-> !dqs_oe_n)
        else $error("strobe high while not driven");
    a_strobe_pulse: assert property ($rose(dqs) |-> s_strobe_high ##1 s_strobe_free)
        else $error("strobe pulse wrong length");
    a_ref_pd_gap: assert property ($fell(cke) |-> ref_r >= REFPDEN_NCK + XPDLL_MIN_NCK)
        else $error("power-down entered too soon after refresh");
    a_read_locked: assert property (issue && (cmd == CMD_RD || cmd == CMD_RDA) |-> exit_r >= XPDLL_MIN_NCK)
        else $error("read too soon after wake-up");
endmodule

// ==== verification/tb_ddr3_sdram_cycle_timing_rules.sv ====
// Purpose: Drives the controller end against the memory end.
// Assumes: Link clock made by the controller, 200 ns period.
// Notes:   Expected values come from the mode settings written.
`timescale 1ns/1ps
module tb_ddr3_sdram_cycle_timing_rules;
    import ddr_link_pkg::*;
    localparam int DLY = 1;
    logic        clk_sys;
    logic        rstn;
    logic        req_valid;
    cmd_t        req_cmd;
    logic [15:0] req_addr;
    logic        req_ready;
    logic        pd_req;
    logic        pd_active;
    logic        ref_due;
    logic        lev_done;
    logic        lev_result;
    logic        int_write_start;
    logic [4:0]  write_recovery;
    logic        power_down;
    logic        calibrating;
    logic        cal_step;
    logic        leveling;
    int          n_errors;
    int          n_tests;
    int          b;

    ddr_link_if ddr_link_if_i ();
    ddr_ctrl_end #(.DIV(CK_DIV)) ddr_ctrl_end_i (.link(ddr_link_if_i), .clk_sys(clk_sys), .rstn(rstn),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr), .req_ready(req_ready), .pd_req(pd_req),
        .pd_active(pd_active), .ref_due(ref_due), .lev_done(lev_done), .lev_result(lev_result));
    ddr_dram_end ddr_dram_end_i (.link(ddr_link_if_i), .clk_sys(clk_sys), .rstn(rstn),
        .int_write_start(int_write_start), .write_recovery(write_recovery), .power_down(power_down),
        .calibrating(calibrating), .cal_step(cal_step), .leveling(leveling));
    ddr_link_monitor ddr_link_monitor_i (.clk_sys(clk_sys), .rstn(rstn), .ck(ddr_link_if_i.ck),
        .cke(ddr_link_if_i.cke), .cmd(ddr_link_if_i.cmd), .addr(ddr_link_if_i.addr), .dqs(ddr_link_if_i.dqs),
        .dqs_oe_n(ddr_link_if_i.dqs_oe_n), .lev_fb(ddr_link_if_i.lev_fb));

    ////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // A wait that ran out ends the run
    task automatic hang();
        n_errors++;
        $display("ERROR t=%0t got %h exp %h (wait ran out)", $time, 1'b0, 1'b1);
        close_out();
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return lev_done;
            1: return pd_active;
            2: return power_down;
            3: return ref_due;
            4: return ddr_link_if_i.cke;
            default: return leveling;
        endcase
    endfunction

    task automatic wait_on(input int s, input logic v);
        int k;
        for (k = 0; k < 4000; k++) begin
            @(posedge clk_sys);
            if (pick(s) === v) break;
        end
        if (k == 4000) hang();
    endtask

    // Request held until taken with ready high
    task automatic send(input cmd_t c, input logic [15:0] a);
        int k;
        @(posedge clk_sys);
        #DLY;
        req_valid = 1'b1;
        req_cmd   = c;
        req_addr  = a;
        for (k = 0; k < 4000; k++) begin
            @(posedge clk_sys);
            if (req_ready === 1'b1) break;
        end
        if (k == 4000) hang();
        #DLY;
        req_valid = 1'b0;
    endtask

    // Link rises from the command's own rise to the device pulse
    task automatic timed(input cmd_t c, input logic [15:0] a, input logic sel, input int exp);
        int   k;
        int   n;
        logic ckq;
        logic seen;
        send(c, a);
        n    = 0;
        seen = 1'b0;
        ckq  = ddr_link_if_i.ck;
        for (k = 0; k < 4000; k++) begin
            @(posedge clk_sys);
            if (ddr_link_if_i.ck === 1'b1 && ckq === 1'b0) begin
                if (seen) n++;
                else if (ddr_link_if_i.cmd === c) seen = 1'b1;
            end
            ckq = ddr_link_if_i.ck;
            if (seen && (sel ? cal_step : int_write_start) === 1'b1) break;
        end
        if (k == 4000) hang();
        chk(16'(n), 16'(exp));
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial begin
        rstn      = 1'b0;
        req_valid = 1'b0;
        req_cmd   = CMD_NOP;
        req_addr  = 16'h0000;
        pd_req    = 1'b0;
        n_errors  = 0;
        n_tests   = 0;
        repeat (2) @(posedge clk_sys);
        #DLY rstn = 1'b1;
        chk(16'(write_recovery), 16'(WR_CODE0_CYC));
        // Write latency 6, then burst modes 0 to 2
        send(CMD_MRS, 16'h8008);
        for (b = 0; b < 3; b++) begin
            send(CMD_MRS, 16'h0600 | 16'(b));
            timed(CMD_WR, 16'h0000, 1'b0, int'(CWL_BASE) + 1 + (b == 2 ? int'(WR_OFS_BC4) : int'(WR_OFS_BL8)));
        end
        chk(16'(write_recovery), 16'(3 + WR_CODE_BASE));
        $display("test write_start done");
        timed(CMD_SHORT_CALIBRATION_CMD, 16'h0000, 1'b1, int'(SHORT_CALIBRATION_CMD_NCK));
        chk(16'(calibrating), 16'h0000);
        send(CMD_ACT, 16'h0000);
        $display("test calibration done");
        send(CMD_MRS, 16'h4080);
        wait_on(5, 1'b1);
        wait_on(0, 1'b1);
        chk(16'(lev_result), 16'h0000);
        send(CMD_MRS, 16'h4000);
        wait_on(5, 1'b0);
        $display("test leveling done");
        // Power-down requested while a row activation is busy
        send(CMD_ACT, 16'h0000);
        pd_req = 1'b1;
        wait_on(1, 1'b1);
        chk(16'(ddr_link_if_i.cke), 16'h0000);
        wait_on(2, 1'b1);
        #DLY pd_req = 1'b0;
        wait_on(4, 1'b1);
        send(CMD_RD, 16'h0000);
        wait_on(2, 1'b0);
        $display("test power_down done");
        wait_on(3, 1'b1);
        wait_on(3, 1'b0);
        $display("test refresh done");
        close_out();
    end
endmodule
